// ==== rsc_consts.svh ====
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// register byte offsets
`define RSC_OFF_SRC 12'h000
`define RSC_OFF_CFG 12'h004
`define RSC_OFF_STAT 12'h008

// reset source flag positions
`define RSC_SRC_POR 7
`define RSC_SRC_PIN 6
`define RSC_SRC_COP 5
`define RSC_SRC_ILLEGAL_OPCODE_FLAG 4
`define RSC_SRC_ILLEGAL_ADDRESS_FLAG 3
`define RSC_SRC_MENR 2
`define RSC_SRC_LVI 1
`define RSC_SRC_POR_VAL 8'h80
`define RSC_SRC_RST 8'h00

// config fields
`define RSC_CFG_WDDIS 0
`define RSC_CFG_STOPEN 1
`define RSC_CFG_RST 2'h0

// timing counts, in crystal_clock cycles unless noted
`define RSC_CNT_W 13
`define RSC_CNT_LAST 13'h0FFF
`define RSC_PIN_CYC 7'h20
`define RSC_TAIL_INT 7'h20
`define RSC_TAIL_LONG 7'h40
`define RSC_LV_CPU_CYC 4'h9
`define RSC_ERASED 8'hFF
`define RSC_SWI_CODE 4'h8

`endif

// ==== rsc_pkg.sv ====
package rsc_pkg;

  localparam int NIRQ = 8;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b000,
    RS_LONG = 3'b001,
    RS_PIN32 = 3'b010,
    RS_TAIL = 3'b011,
    RS_EXT = 3'b100
  } rsc_rst_state_type;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_WAIT = 2'b01,
    PM_STOP = 2'b10,
    PM_RECOV = 2'b11
  } rsc_pm_state_type;

  typedef struct packed {
    logic illegal_opcode;
    logic stop_exec;
    logic wait_exec;
    logic opcode_fetch;
    logic fetch_legal;
    logic vector_fetch;
    logic [7:0] vector_byte;
    logic instr_done;
    logic software_trap_instruction;
    logic service_done;
    logic mask_bit;
    logic brk;
  } rsc_cpu_in_type;

  typedef struct packed {
    logic stack_start;
    logic mask_set;
    logic mask_clr;
    logic [3:0] vector_sel;
    logic vector_valid;
  } rsc_cpu_out_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic base_clk_en;
    logic xclk_en;
  } rsc_clk_en_type;

endpackage

// ==== rsc_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rsc_consts.svh"
module rsc_top (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // asynchronous pins
  input wire logic I_XCLK,
  input wire logic I_POWER_ON_PULSE,
  input wire logic I_LV_BELOW,
  input wire logic I_RST_PIN_IN,
  output logic O_RST_PIN_OUT,
  output logic O_RST_PIN_OE,
  // cpu and peripherals
  input wire rsc_pkg::rsc_cpu_in_type I_CPU,
  input wire logic I_WATCHDOG_TIMEOUT,
  input wire logic [rsc_pkg::NIRQ-1:0] I_IRQ_REQ,
  input wire logic [rsc_pkg::NIRQ-1:0] I_IRQ_EN,
  output rsc_pkg::rsc_cpu_out_type O_CPU,
  output rsc_pkg::rsc_clk_en_type O_CLK_EN,
  output logic O_INTERNAL_RESET,
  output logic O_MONITOR_MODE,
  output logic O_WATCHDOG_CLK,
  output logic O_WATCHDOG_EN
);
  import rsc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] xclk_sync_q, por_sync_q, lv_sync_q, pin_sync_q;
  logic xclk_prev_q;
  logic tick;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      xclk_sync_q <= 2'h0;
      por_sync_q <= 2'h0;
      lv_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
      xclk_prev_q <= 1'b0;
    end else begin
      xclk_sync_q <= {xclk_sync_q[0], I_XCLK};
      por_sync_q <= {por_sync_q[0], I_POWER_ON_PULSE};
      lv_sync_q <= {lv_sync_q[0], I_LV_BELOW};
      pin_sync_q <= {pin_sync_q[0], I_RST_PIN_IN};
      xclk_prev_q <= xclk_sync_q[1];
    end
  end

  // falling edge of the crystal clock, seen two cycles late
  assign tick = xclk_prev_q & ~xclk_sync_q[1];

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  rsc_rst_state_type rs_q, rs_d;
  rsc_pm_state_type pm_q;
  logic [`RSC_CNT_W-1:0] cnt_q;
  logic [6:0] rcnt_q, tail_len_q;
  logic [3:0] lv_cnt_q;
  logic [7:0] src_q;
  logic [1:0] cfg_q;
  logic monitor_q;
  logic latched_q, mask_prev_q;
  logic [3:0] vec_q;
  logic cnt_last, cpu_tick, in_rst, pin_low_ext;
  logic src_por, src_lvi, src_cop, src_illegal_opcode_flag, src_illegal_address_flag, src_menr, long_src, short_src;
  logic [7:0] src_set;
  logic apb_acc, apb_wr, apb_rd, apb_hit, src_rd_clr;
  logic [NIRQ-1:0] hw_pend;
  logic hw_any;
  logic [3:0] best;

  assign cnt_last = tick && (cnt_q == `RSC_CNT_LAST);
  assign cpu_tick = tick && (cnt_q[1:0] == 2'h3);
  assign in_rst = (rs_q != RS_IDLE);
  // our own drive also pulls the pin low, so only idle state reads it as a request
  assign pin_low_ext = ~pin_sync_q[1] && !O_RST_PIN_OE;

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  assign src_por = por_sync_q[1];
  assign src_lvi = lv_sync_q[1] && cpu_tick && (lv_cnt_q == `RSC_LV_CPU_CYC - 4'h1);
  assign src_cop = I_WATCHDOG_TIMEOUT;
  assign src_illegal_opcode_flag = I_CPU.illegal_opcode ||
                    (I_CPU.stop_exec && !cfg_q[`RSC_CFG_STOPEN]);
  // only opcode fetches are checked; data reads never reach here
  assign src_illegal_address_flag = I_CPU.opcode_fetch && !I_CPU.fetch_legal;
  assign src_menr = I_CPU.vector_fetch && (I_CPU.vector_byte == `RSC_ERASED);
  assign long_src = src_por || src_lvi;
  assign short_src = src_cop || src_illegal_opcode_flag || src_illegal_address_flag || src_menr;

  // consecutive low-supply cpu cycles, saturating so one dip gives one reset
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      lv_cnt_q <= 4'h0;
    end else if (!lv_sync_q[1]) begin
      lv_cnt_q <= 4'h0;
    end else if (cpu_tick && lv_cnt_q != `RSC_LV_CPU_CYC) begin
      lv_cnt_q <= lv_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------
  // stabilisation counter
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cnt_q <= '0;
    end else if ((rs_d == RS_LONG || rs_d == RS_PIN32) && rs_q != rs_d) begin
      cnt_q <= '0; // internal resets restart the count; pin reset does not
    end else if (pm_q == PM_STOP) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_WATCHDOG_CLK <= 1'b0;
      O_WATCHDOG_EN <= 1'b0;
    end else begin
      // the full 13-bit wrap clocks the watchdog, not the 4095 stabilisation mark
      O_WATCHDOG_CLK <= tick && (&cnt_q) && pm_q != PM_RECOV;
      O_WATCHDOG_EN <= !cfg_q[`RSC_CFG_WDDIS];
    end
  end

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  always_comb begin
    rs_d = rs_q;
    case (rs_q)
      RS_IDLE: begin
        // any source starts a reset at once; long sources win over short ones, short ones over the pin
        if (long_src) begin
          rs_d = RS_LONG;
        end else if (short_src) begin
          rs_d = RS_PIN32;
        end else if (pin_low_ext) begin
          rs_d = RS_EXT;
        end
      end
      RS_LONG: begin
        if (cnt_last) begin
          rs_d = RS_TAIL;
        end
      end
      RS_PIN32: begin
        if (tick && rcnt_q == `RSC_PIN_CYC - 7'h01) begin
          rs_d = RS_TAIL;
        end
      end
      RS_TAIL: begin
        if (tick && rcnt_q == tail_len_q - 7'h01) begin
          rs_d = RS_IDLE;
        end
      end
      RS_EXT: begin
        if (pin_sync_q[1]) begin
          rs_d = RS_TAIL;
        end
      end
      default: begin
        rs_d = RS_IDLE;
      end
    endcase
    // power-on or low voltage enters the long hold from any other state; a hold in progress is not restarted
    if (long_src && rs_q != RS_LONG) begin
      rs_d = RS_LONG;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      rs_q <= RS_LONG;
      rcnt_q <= 7'h00;
      tail_len_q <= `RSC_TAIL_LONG;
    end else begin
      rs_q <= rs_d;
      if (rs_d != rs_q) begin
        rcnt_q <= 7'h00;
      end else if (tick) begin
        rcnt_q <= rcnt_q + 7'h01;
      end
      if (rs_q == RS_LONG || rs_q == RS_EXT) begin
        tail_len_q <= `RSC_TAIL_LONG;
      end else if (rs_q == RS_PIN32) begin
        tail_len_q <= `RSC_TAIL_INT;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_RST_PIN_OUT <= 1'b0;
      O_RST_PIN_OE <= 1'b1;
      O_INTERNAL_RESET <= 1'b1;
    end else begin
      O_RST_PIN_OUT <= 1'b0;
      O_RST_PIN_OE <= (rs_d == RS_LONG || rs_d == RS_PIN32);
      O_INTERNAL_RESET <= (rs_d != RS_IDLE);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      monitor_q <= 1'b0;
    end else if (src_por) begin
      monitor_q <= 1'b0;
    end else if (src_menr && !in_rst) begin
      monitor_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // reset source register
  // ----------------------------------------
  always_comb begin
    src_set = 8'h00;
    if (!in_rst) begin
      src_set[`RSC_SRC_COP] = src_cop;
      src_set[`RSC_SRC_ILLEGAL_OPCODE_FLAG] = src_illegal_opcode_flag;
      src_set[`RSC_SRC_ILLEGAL_ADDRESS_FLAG] = src_illegal_address_flag;
      src_set[`RSC_SRC_MENR] = src_menr;
      src_set[`RSC_SRC_PIN] = pin_low_ext;
    end
    src_set[`RSC_SRC_LVI] = src_lvi;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      src_q <= `RSC_SRC_POR_VAL;
    end else if (src_por) begin
      src_q <= `RSC_SRC_POR_VAL;
    end else if (src_rd_clr) begin
      src_q <= src_set; // set wins over the read clear
    end else begin
      src_q <= src_q | src_set;
    end
  end

  // ----------------------------------------
  // interrupt arbitration
  // ----------------------------------------
  assign hw_pend = I_IRQ_REQ & I_IRQ_EN;
  assign hw_any = |hw_pend;

  // index 0 is the highest priority
  always_comb begin
    best = 4'h0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (hw_pend[i]) begin
        best = 4'(i);
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      pm_q <= PM_RUN;
      latched_q <= 1'b0;
      vec_q <= 4'h0;
      mask_prev_q <= 1'b1;
      O_CPU <= '0;
    end else begin
      mask_prev_q <= I_CPU.mask_bit;
      O_CPU.stack_start <= 1'b0;
      O_CPU.mask_set <= 1'b0;
      O_CPU.mask_clr <= 1'b0;
      if (in_rst) begin
        pm_q <= PM_RUN;
        latched_q <= 1'b0;
      end else begin
        case (pm_q)
          PM_RUN: begin
            if (latched_q && (I_CPU.service_done || (mask_prev_q && !I_CPU.mask_bit))) begin
              latched_q <= 1'b0;
            end else if (!latched_q && I_CPU.instr_done) begin
              if (I_CPU.software_trap_instruction) begin
                latched_q <= 1'b1;
                vec_q <= `RSC_SWI_CODE;
                O_CPU.stack_start <= 1'b1;
                O_CPU.mask_set <= 1'b1;
              end else if (hw_any && !I_CPU.mask_bit) begin
                latched_q <= 1'b1;
                vec_q <= best;
                O_CPU.stack_start <= 1'b1;
                O_CPU.mask_set <= 1'b1;
              end else if (I_CPU.wait_exec) begin
                pm_q <= PM_WAIT;
                O_CPU.mask_clr <= 1'b1;
              end else if (I_CPU.stop_exec && cfg_q[`RSC_CFG_STOPEN]) begin
                pm_q <= PM_STOP;
              end
            end
          end
          PM_WAIT: begin
            if (hw_any) begin
              pm_q <= PM_RUN;
              latched_q <= 1'b1;
              vec_q <= best;
              O_CPU.stack_start <= 1'b1;
              O_CPU.mask_set <= 1'b1;
            end
          end
          PM_STOP: begin
            if (hw_any || I_CPU.brk) begin
              pm_q <= PM_RECOV;
            end
          end
          PM_RECOV: begin
            if (cnt_last) begin
              pm_q <= PM_RUN;
              if (hw_any) begin
                latched_q <= 1'b1;
                vec_q <= best;
                O_CPU.stack_start <= 1'b1;
                O_CPU.mask_set <= 1'b1;
              end
            end
          end
          default: begin
            pm_q <= PM_RUN;
          end
        endcase
      end
      O_CPU.vector_sel <= vec_q;
      O_CPU.vector_valid <= latched_q;
    end
  end

  // ----------------------------------------
  // clock enables
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_CLK_EN <= '0;
      O_MONITOR_MODE <= 1'b0;
    end else begin
      O_CLK_EN.cpu_clk_en <= !in_rst && pm_q == PM_RUN;
      O_CLK_EN.bus_clk_en <= rs_q != RS_LONG && pm_q != PM_STOP &&
                             pm_q != PM_RECOV;
      O_CLK_EN.base_clk_en <= pm_q != PM_STOP;
      O_CLK_EN.xclk_en <= pm_q != PM_STOP;
      O_MONITOR_MODE <= monitor_q && !in_rst;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  assign apb_acc = I_PSEL && I_PENABLE && O_PREADY;
  assign apb_wr = apb_acc && I_PWRITE;
  assign apb_rd = apb_acc && !I_PWRITE;
  assign apb_hit = (I_PADDR == `RSC_OFF_SRC) || (I_PADDR == `RSC_OFF_CFG) ||
                   (I_PADDR == `RSC_OFF_STAT);
  assign src_rd_clr = apb_rd && I_PADDR == `RSC_OFF_SRC;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cfg_q <= `RSC_CFG_RST;
    end else if (apb_wr && I_PADDR == `RSC_OFF_CFG) begin
      cfg_q <= I_PWDATA[1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else begin
      O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !apb_hit;
      if (I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE) begin
        case (I_PADDR)
          `RSC_OFF_SRC: O_PRDATA <= {24'h000000, src_q};
          `RSC_OFF_CFG: O_PRDATA <= {30'h00000000, cfg_q};
          `RSC_OFF_STAT: O_PRDATA <= {20'h00000, monitor_q, latched_q, vec_q,
                                      pm_q, 1'b0, rs_q};
          default: O_PRDATA <= 32'h00000000;
        endcase
      end else begin
        O_PRDATA <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rsc_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsc_cpu_model
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // bench commands
  input wire rsc_cpu_in_type i_cmd,
  input wire logic i_slow,
  // controller side
  input wire rsc_cpu_out_type i_out,
  output rsc_cpu_in_type o_cpu
);
  logic mask_q, saved_q, done_q;
  logic [3:0] wait_q;
  always_comb begin
    o_cpu = i_cmd;
    o_cpu.mask_bit = mask_q;
    o_cpu.service_done = done_q;
  end
  // ----------
  // i bit and service routine; return restores the stacked mask
  // ----------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mask_q <= 1'b1;
      saved_q <= 1'b1;
      done_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      done_q <= 1'b0;
      if (i_out.mask_set) begin
        saved_q <= mask_q;
        mask_q <= 1'b1;
      end else if (i_out.mask_clr || i_cmd.mask_bit) begin
        mask_q <= 1'b0;
      end
      if (i_out.vector_valid && !done_q) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= (i_slow ? 4'h9 : 4'h1)) begin
          done_q <= 1'b1;
          mask_q <= saved_q;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rsc_top_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsc_top_checker
  import rsc_pkg::*;
(
  // clock, reset, pins
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_XCLK,
  input wire logic O_RST_PIN_OE,
  input wire logic O_INTERNAL_RESET,
  // cpu side
  input wire rsc_cpu_in_type I_CPU,
  input wire logic [NIRQ-1:0] I_IRQ_REQ,
  input wire logic [NIRQ-1:0] I_IRQ_EN,
  input wire rsc_cpu_out_type O_CPU,
  input wire rsc_clk_en_type O_CLK_EN
);
  logic [2:0] xs_q;
  logic [12:0] pin_t_q, tail_t_q;
  logic [3:0] sel_q;
  logic idle, tick, pend;
  function automatic logic [3:0] first_irq(input logic [NIRQ-1:0] p);
    first_irq = 4'h0;
    for (int i = NIRQ - 1; i >= 0; i--) if (p[i]) first_irq = i[3:0];
  endfunction
  // tick counts allow a couple of ticks of synchroniser skew
  assign tick = xs_q[2] & ~xs_q[1];
  assign pend = |(I_IRQ_REQ & I_IRQ_EN);
  assign idle = !O_RST_PIN_OE && !O_INTERNAL_RESET && O_CLK_EN.cpu_clk_en;
  always_ff @(posedge I_CLK) begin
    xs_q <= {xs_q[1:0], I_XCLK};
    sel_q <= first_irq(I_IRQ_REQ & I_IRQ_EN);
    pin_t_q <= (!O_RST_PIN_OE || !I_NRST) ? 13'h0 : pin_t_q + {12'h0, tick};
    tail_t_q <= O_RST_PIN_OE ? 13'h0 : tail_t_q + {12'h0, tick};
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  illegal_opcode_flag_reset_a: assert property (
    idle && (I_CPU.illegal_opcode || I_CPU.stop_exec) |=> O_RST_PIN_OE && O_INTERNAL_RESET)
    else $error("illegal opcode gave no reset");
  bad_fetch_a: assert property (
    idle && I_CPU.opcode_fetch && !I_CPU.fetch_legal |=> O_RST_PIN_OE)
    else $error("illegal fetch gave no reset");
  erased_vec_a: assert property (
    idle && I_CPU.vector_fetch && I_CPU.vector_byte == 8'hFF |=> O_INTERNAL_RESET)
    else $error("erased vector gave no reset");
  pin_len_a: assert property (
    $fell(O_RST_PIN_OE) |-> pin_t_q inside {[30:34], [4093:4099]})
    else $error("reset pin low time wrong");
  tail_len_a: assert property (
    $fell(O_INTERNAL_RESET) |-> tail_t_q inside {[30:34], [62:66]})
    else $error("internal reset tail wrong");
  irq_entry_a: assert property (
    idle && I_CPU.instr_done && !I_CPU.software_trap_instruction && !I_CPU.mask_bit && pend && !O_CPU.vector_valid
    && !O_CPU.stack_start |=> O_CPU.stack_start && O_CPU.mask_set
    ##1 O_CPU.vector_valid && O_CPU.vector_sel == $past(sel_q))
    else $error("interrupt entry wrong");
  swi_entry_a: assert property (
    idle && I_CPU.instr_done && I_CPU.software_trap_instruction && !O_CPU.vector_valid && !O_CPU.stack_start
    |=> O_CPU.stack_start ##1 O_CPU.vector_sel == 4'h8)
    else $error("software trap entry wrong");
  latch_hold_a: assert property (
    O_CPU.vector_valid && $past(O_CPU.vector_valid) |-> $stable(O_CPU.vector_sel))
    else $error("latched vector changed");
  wait_entry_a: assert property (
    idle && I_CPU.instr_done && I_CPU.wait_exec && !I_CPU.software_trap_instruction && !pend && !O_CPU.vector_valid
    |-> ##[1:2] O_CPU.mask_clr ##[0:2] (!O_CLK_EN.cpu_clk_en && O_CLK_EN.bus_clk_en))
    else $error("wait entry wrong");
  wake_a: assert property (
    !O_CLK_EN.cpu_clk_en && O_CLK_EN.bus_clk_en && !O_INTERNAL_RESET && $rose(pend)
    |=> O_CPU.stack_start)
    else $error("no wake from wait");
  cover property (O_CPU.stack_start && !O_CLK_EN.cpu_clk_en);
  cover property ($fell(O_INTERNAL_RESET));
  cover property (O_CPU.vector_valid && O_CPU.vector_sel == 4'h8);
endmodule
`default_nettype wire

// ==== tb_reset_exception_controller.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_reset_exception_controller;
  import rsc_pkg::*;
  logic clk, nrst, xclk, psel, pen, pwr, slow, rdy, err, e, oe, internal_reset, mon, wdclk, wden, pout;
  logic pin;
  logic lv, wdt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [NIRQ-1:0] req, en;
  rsc_cpu_in_type cmd, cpu;
  rsc_cpu_in_type src_cmd [4];
  logic [31:0] src_exp [4];
  rsc_cpu_out_type co;
  rsc_clk_en_type ce;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int q[$];
  // open-drain reset pin with pull-up
  assign pin = ~oe;
  rsc_top u_rsc_top (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(err),
    .I_XCLK(xclk), .I_POWER_ON_PULSE(1'b0), .I_LV_BELOW(lv), .I_RST_PIN_IN(pin),
    .O_RST_PIN_OUT(pout), .O_RST_PIN_OE(oe), .I_CPU(cpu), .I_WATCHDOG_TIMEOUT(wdt),
    .I_IRQ_REQ(req), .I_IRQ_EN(en), .O_CPU(co), .O_CLK_EN(ce), .O_INTERNAL_RESET(internal_reset),
    .O_MONITOR_MODE(mon), .O_WATCHDOG_CLK(wdclk), .O_WATCHDOG_EN(wden));
  rsc_cpu_model u_rsc_cpu_model (.i_clk(clk), .i_nrst(nrst), .i_cmd(cmd), .i_slow(slow),
    .i_out(co), .o_cpu(cpu));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    xclk = 1'b0;
    forever #40 xclk = ~xclk;
  end
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // two long holds of 4096 slow ticks dominate the run
    if (cyc == 90000) begin
      failures++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ----------
  // bus and cpu drivers, entered just after a rising edge
  // ----------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input rsc_cpu_in_type c);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
    @(posedge clk);
  endtask
  // waits have no timeout of their own; only the bench timeout ends a hung one
  task automatic settle();
    while (internal_reset !== 1'b0) begin
      @(posedge clk);
    end
  endtask
  task automatic wait_valid(input logic v);
    while (co.vector_valid !== v) begin
      @(posedge clk);
    end
  endtask
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    cmd = '0;
    slow = 1'b0;
    req = '0;
    en = '0;
    lv = 1'b0;
    wdt = 1'b0;
    seed = 32'h0C20;
    src_cmd = '{'{illegal_opcode:1'b1, default:'0}, '{stop_exec:1'b1, default:'0},
      '{opcode_fetch:1'b1, default:'0}, '{vector_fetch:1'b1, vector_byte:8'hFF, default:'0}};
    src_exp = '{32'h10, 32'h10, 32'h08, 32'h04};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (100) @(posedge clk);
    check(ce.bus_clk_en, 1'b0);
    check(oe, 1'b1);
    settle();
    check(ce.bus_clk_en, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h80);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check(e, 1'b1);
    apb(1'b1, 12'h004, 32'h1);
    @(posedge clk);
    check(wden, 1'b0);
    apb(1'b1, 12'h004, 32'h0);
    @(posedge clk);
    check(wden, 1'b1);
    pulse('{opcode_fetch:1'b1, fetch_legal:1'b1, default:'0});
    pulse('{vector_fetch:1'b1, vector_byte:8'h7E, default:'0});
    check(internal_reset, 1'b0);
    for (int i = 0; i < 4; i++) begin
      pulse(src_cmd[i]);
      check(oe, 1'b1);
      check(pout, 1'b0);
      settle();
      apb(1'b0, 12'h000, 32'h0);
      check(rd, src_exp[i]);
    end
    check(mon, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h800);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    @(posedge clk);
    check(oe, 1'b1);
    settle();
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h20);
    // the i bit is set out of reset, so a pending source must wait
    req <= 8'h01;
    en <= 8'h01;
    pulse('{instr_done:1'b1, default:'0});
    repeat (3) @(posedge clk);
    check(co.vector_valid, 1'b0);
    pulse('{instr_done:1'b1, software_trap_instruction:1'b1, default:'0});
    wait_valid(1'b1);
    check(co.vector_sel, 4'h8);
    wait_valid(1'b0);
    pulse('{mask_bit:1'b1, default:'0});
    repeat (6) begin
      seed = xs(seed);
      slow <= seed[20];
      req <= seed[7:0] | (8'h01 << seed[18:16]);
      en <= seed[15:8] | (8'h01 << seed[18:16]);
      @(posedge clk);
      q = {};
      for (int i = 0; i < NIRQ; i++) if (req[i] && en[i]) q.push_back(i);
      while (q.size() > 0) begin
        pulse('{instr_done:1'b1, default:'0});
        wait_valid(1'b1);
        check(co.vector_sel, q[0]);
        wait_valid(1'b0);
        req[q[0]] <= 1'b0;
        q.delete(0);
        @(posedge clk);
      end
    end
    req <= '0;
    @(posedge clk);
    pulse('{instr_done:1'b1, wait_exec:1'b1, default:'0});
    repeat (3) @(posedge clk);
    check(ce.cpu_clk_en, 1'b0);
    check(ce.bus_clk_en, 1'b1);
    req <= 8'h08;
    en <= 8'h08;
    wait_valid(1'b1);
    check(co.vector_sel, 4'h3);
    wait_valid(1'b0);
    // low supply while waiting: no reset before nine cpu cycles, then the long hold
    req <= '0;
    pulse('{instr_done:1'b1, wait_exec:1'b1, default:'0});
    lv <= 1'b1;
    repeat (200) @(posedge clk);
    check(internal_reset, 1'b0);
    repeat (200) @(posedge clk);
    check(oe, 1'b1);
    check(ce.bus_clk_en, 1'b0);
    lv <= 1'b0;
    settle();
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h02);
    check(ce.cpu_clk_en, 1'b1);
    finish_test();
  end
endmodule
bind rsc_top rsc_top_checker u_rsc_top_checker (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_XCLK(I_XCLK),
  .O_RST_PIN_OE(O_RST_PIN_OE), .O_INTERNAL_RESET(O_INTERNAL_RESET), .I_CPU(I_CPU),
  .I_IRQ_REQ(I_IRQ_REQ), .I_IRQ_EN(I_IRQ_EN), .O_CPU(O_CPU), .O_CLK_EN(O_CLK_EN));
`default_nettype wire
